// ===== src/mcs_cycle_dec.sv
/*
 * Cycle decoder: maps instruction, form, phase and state to the bus
 * source, direction, data select and end-of-sequence flag.
 * Assumes the sequencer drives only reachable state numbers.
 */
`timescale 1ns/100ps
module mcs_cycle_dec
   import mcs_pkg::*;
(
   mcs_dec_if.dec d
);

   always_comb begin
      d.src  = MCS_AS_NONE;
      d.rd   = 1'b0;
      d.wr   = 1'b0;
      d.dsel = MCS_DS_NONE;
      d.last = 1'b0;
      case (d.instr)
         MCS_INS_BIT_ZERO, MCS_INS_BIT_ONE: begin
            if (d.state >= 4'h2 && d.state <= 4'h4) begin
               d.src = MCS_AS_OPC1;
               d.rd  = 1'b1;
            end
            d.last = (d.state == 4'h3) || (d.state == 4'h6) || (d.state == 4'h7);
         end
         MCS_INS_RJUMP: begin
            if (d.state >= 4'h1 && d.state <= 4'h3) begin
               d.src = MCS_AS_OPC1;
               d.rd  = 1'b1;
            end
            d.last = (d.state == 4'h2) || (d.state == 4'h5) || (d.state == 4'h6);
         end
         MCS_INS_TRAP: begin
            d.rd = (d.state >= 4'h3) && (d.state <= 4'h6);
            case (d.state)
               4'h3, 4'h4: d.src = MCS_AS_VEC;
               4'h5, 4'h6: d.src = MCS_AS_VEC_M1;
               4'h7: begin
                  d.src  = MCS_AS_SP;
                  d.wr   = 1'b1;
                  d.dsel = MCS_DS_PCH;
               end
               4'h9: begin
                  d.src  = MCS_AS_SP1;
                  d.wr   = 1'b1;
                  d.dsel = MCS_DS_PCL;
               end
               default: d.src = MCS_AS_NONE;
            endcase
            d.last = (d.state == MCS_TRAP_LAST);
         end
         MCS_INS_PMOVE: begin
            d.src = MCS_AS_PERIPH;
            d.wr  = 1'b1;
            case (mcs_form_t'(d.form))
               MCS_FORM_A:   d.dsel = MCS_DS_REG_A;
               MCS_FORM_B:   d.dsel = MCS_DS_REG_B;
               default:      d.dsel = MCS_DS_IMM;
            endcase
            d.last = (d.state == 4'h2);
         end
         MCS_INS_DMOVE: begin
            if (d.phase == MCS_PH_FUNC) begin
               case (d.state)
                  4'h2, 4'h3: begin
                     d.src = (d.form == MCS_DM_IDX) ? MCS_AS_OPC3 : MCS_AS_OPC2;
                     d.rd  = 1'b1;
                  end
                  4'h5: begin
                     d.src  = MCS_AS_DEST;
                     d.wr   = 1'b1;
                     d.dsel = MCS_DS_LSB;
                  end
                  4'h7: begin
                     d.src  = MCS_AS_DEST_M1;
                     d.wr   = 1'b1;
                     d.dsel = MCS_DS_MSB;
                  end
                  default: d.src = MCS_AS_NONE;
               endcase
               d.last = (d.state == 4'h7);
            end else if (d.form == MCS_DM_REG) begin
               case (d.state)
                  4'h1, 4'h2: d.src = MCS_AS_OPC1;
                  4'h3:       d.src = MCS_AS_SRC;
                  4'h4:       d.src = MCS_AS_SRC_M1;
                  default:    d.src = MCS_AS_NONE;
               endcase
               d.rd   = (d.state >= 4'h1) && (d.state <= 4'h4);
               d.last = (d.state == 4'h4);
            end else begin
               if (d.form == MCS_DM_IDX) begin
                  case (d.state)
                     4'h2, 4'h3: d.src = MCS_AS_OPC1;
                     4'h4, 4'h5: d.src = MCS_AS_OPC2;
                     default:    d.src = MCS_AS_NONE;
                  endcase
                  d.last = (d.state == 4'h7);
               end else begin
                  case (d.state)
                     4'h1, 4'h2: d.src = MCS_AS_OPC1;
                     4'h3, 4'h4: d.src = MCS_AS_OPC2;
                     default:    d.src = MCS_AS_NONE;
                  endcase
                  d.last = (d.state == 4'h5);
               end
               d.rd = (d.src != MCS_AS_NONE);
            end
         end
         default: d.last = 1'b0;
      endcase
   end

endmodule : mcs_cycle_dec

// ===== src/mcs_dec_if.sv
/*
 * Carrier between the sequencer and its cycle decoder.
 * Assumes both ends sit in the same clock domain.
 */
`timescale 1ns/100ps
interface mcs_dec_if;
   import mcs_pkg::*;
   mcs_instr_t instr;
   logic [1:0] form;
   mcs_phase_t phase;
   logic [3:0] state;
   mcs_asrc_t  src;
   logic       rd;
   logic       wr;
   mcs_dsel_t  dsel;
   logic       last;

   modport dec (input instr, form, phase, state, output src, rd, wr, dsel, last);
   modport seq (output instr, form, phase, state, input src, rd, wr, dsel, last);
endinterface : mcs_dec_if

// ===== src/mcs_pkg.sv
/*
 * Package for the bus cycle sequencer: enumerations, field codes and
 * fixed addresses. Assumes a single 100 MHz machine clock domain.
 */
package mcs_pkg;

   // ********************************************
   // Instruction classes, forms and phases
   // ********************************************
   typedef enum logic [2:0] {
      MCS_INS_NONE, MCS_INS_BIT_ZERO, MCS_INS_BIT_ONE, MCS_INS_DMOVE,
      MCS_INS_RJUMP, MCS_INS_TRAP, MCS_INS_PMOVE
   } mcs_instr_t;

   typedef enum logic [1:0] {
      MCS_FORM_A, MCS_FORM_B, MCS_FORM_IMM, MCS_FORM_IDX
   } mcs_form_t;

   localparam logic [1:0] MCS_DM_IMM = 2'h0;
   localparam logic [1:0] MCS_DM_REG = 2'h1;
   localparam logic [1:0] MCS_DM_IDX = 2'h3;

   typedef enum logic [1:0] {MCS_PH_IDLE, MCS_PH_ADDR, MCS_PH_FUNC} mcs_phase_t;

   typedef enum logic [3:0] {
      MCS_AS_NONE, MCS_AS_OPC1, MCS_AS_OPC2, MCS_AS_OPC3, MCS_AS_SP, MCS_AS_SP1,
      MCS_AS_VEC, MCS_AS_VEC_M1, MCS_AS_DEST, MCS_AS_DEST_M1, MCS_AS_SRC,
      MCS_AS_SRC_M1, MCS_AS_PERIPH
   } mcs_asrc_t;

   typedef enum logic [2:0] {
      MCS_DS_NONE, MCS_DS_PCH, MCS_DS_PCL, MCS_DS_REG_A, MCS_DS_REG_B,
      MCS_DS_IMM, MCS_DS_LSB, MCS_DS_MSB
   } mcs_dsel_t;

   // ********************************************
   // Fixed values
   // ********************************************
   localparam logic [15:0] MCS_TRAP_BASE   = 16'hff00;
   localparam logic [15:0] MCS_PERIPH_BASE = 16'h0100;
   localparam logic [3:0]  MCS_STATE_RST   = 4'h0;
   localparam logic [3:0]  MCS_STATE_FIRST = 4'h1;
   localparam logic [3:0]  MCS_TRAP_LAST   = 4'hb;
   localparam int          MCS_SIGN_BIT    = 7;

endpackage : mcs_pkg

// ===== src/mcs_seq.sv
/*
 * Bus cycle sequencer for bit-test jumps, peripheral and double moves,
 * relative jumps and traps. Assumes instruction inputs come from the
 * decoder on the same clock and read data is valid in its read state.
 */
`timescale 1ns/100ps
module mcs_seq
   import mcs_pkg::*;
(
   input  wire logic        core_clk_in,
   input  wire logic        rst_b_in,
   input  wire logic        start_in,
   input  wire logic [2:0]  instr_in,
   input  wire logic [1:0]  form_in,
   input  wire logic [15:0] opc_addr_in,
   input  wire logic [7:0]  opcode_in,
   input  wire logic [7:0]  stack_pointer_in,
   input  wire logic [7:0]  periph_reg_in,
   input  wire logic        bit_test_in,
   input  wire logic        cond_true_in,
   input  wire logic [7:0]  data_in,
   output logic [15:0]      addr_out,
   output logic             rd_out,
   output logic             wr_out,
   output logic [2:0]       dsel_out,
   output logic [3:0]       state_out,
   output logic             busy_out,
   output logic             fetch_out
);

   // ********************************************
   // State and latches
   // ********************************************
   mcs_instr_t  instr_reg,  instr_next;
   logic [1:0]  form_reg,   form_next;
   mcs_phase_t  phase_reg,  phase_next;
   logic [3:0]  state_reg,  state_next;
   logic [15:0] opc_reg,    opc_next;
   logic [7:0]  opcode_reg, opcode_next;
   logic [7:0]  offset_reg, offset_next;
   logic [7:0]  src_reg,    src_next;
   logic [7:0]  dest_reg,   dest_next;
   logic        last_reg;
   logic        fetch_next;
   logic        taken;
   logic [15:0] addr_next;
   logic        rd_next;
   logic        wr_next;
   logic [2:0]  dsel_next;
   logic        last_next;
   logic        busy_next;

   mcs_dec_if dec_bus ();

   mcs_cycle_dec u_dec (
      .d (dec_bus.dec)
   );

   assign dec_bus.instr = instr_next;
   assign dec_bus.form  = form_next;
   assign dec_bus.phase = phase_next;
   assign dec_bus.state = state_next;

   function automatic logic [15:0] addr_of(input mcs_asrc_t s, input logic [15:0] opc,
                                           input logic [7:0] opcode, input logic [7:0] sp,
                                           input logic [7:0] dst, input logic [7:0] src,
                                           input logic [7:0] pn);
      logic [15:0] vec;
      vec = MCS_TRAP_BASE + {8'h00, opcode};
      case (s)
         MCS_AS_OPC1:    addr_of = opc + 16'h0001;
         MCS_AS_OPC2:    addr_of = opc + 16'h0002;
         MCS_AS_OPC3:    addr_of = opc + 16'h0003;
         MCS_AS_SP:      addr_of = {8'h00, sp};
         MCS_AS_SP1:     addr_of = {8'h00, sp + 8'h01};
         MCS_AS_VEC:     addr_of = vec;
         MCS_AS_VEC_M1:  addr_of = vec - 16'h0001;
         MCS_AS_DEST:    addr_of = {8'h00, dst};
         MCS_AS_DEST_M1: addr_of = {8'h00, dst - 8'h01};
         MCS_AS_SRC:     addr_of = {8'h00, src};
         MCS_AS_SRC_M1:  addr_of = {8'h00, src - 8'h01};
         MCS_AS_PERIPH:  addr_of = MCS_PERIPH_BASE + {8'h00, pn};
         default:        addr_of = 16'h0000;
      endcase
   endfunction : addr_of

   // ********************************************
   // Next state
   // ********************************************
   always_comb begin
      instr_next  = instr_reg;
      form_next   = form_reg;
      phase_next  = phase_reg;
      state_next  = state_reg + 4'h1;
      opc_next    = opc_reg;
      opcode_next = opcode_reg;
      offset_next = offset_reg;
      src_next    = src_reg;
      dest_next   = dest_reg;
      fetch_next  = 1'b0;
      taken       = (instr_reg == MCS_INS_BIT_ZERO) ? !bit_test_in : bit_test_in;
      case (phase_reg)
         MCS_PH_IDLE: begin
            state_next = MCS_STATE_RST;
            if (start_in && instr_in != 3'h0 && instr_in != 3'h7) begin
               instr_next  = mcs_instr_t'(instr_in);
               form_next   = form_in;
               opc_next    = opc_addr_in;
               opcode_next = opcode_in;
               state_next  = MCS_STATE_FIRST;
               phase_next  = (mcs_instr_t'(instr_in) == MCS_INS_DMOVE) ? MCS_PH_ADDR
                                                                       : MCS_PH_FUNC;
            end
         end
         default: begin
            if (instr_reg == MCS_INS_DMOVE && phase_reg == MCS_PH_ADDR && state_reg == 4'h2
                && form_reg == MCS_DM_REG) begin
               src_next = data_in;
            end
            if (instr_reg == MCS_INS_DMOVE && phase_reg == MCS_PH_FUNC
                && state_reg == 4'h3) begin
               dest_next = data_in;
            end
            if (last_reg) begin
               if (phase_reg == MCS_PH_ADDR) begin
                  phase_next = MCS_PH_FUNC;
                  state_next = MCS_STATE_FIRST;
               end else begin
                  phase_next = MCS_PH_IDLE;
                  state_next = MCS_STATE_RST;
                  fetch_next = 1'b1;
               end
            end else begin
               case (instr_reg)
                  MCS_INS_BIT_ZERO, MCS_INS_BIT_ONE: begin
                     if (state_reg == 4'h2) begin
                        state_next = taken ? 4'h4 : 4'h3;
                     end else if (state_reg == 4'h4) begin
                        offset_next = data_in;
                     end else if (state_reg == 4'h5) begin
                        state_next = offset_reg[MCS_SIGN_BIT] ? 4'h6 : 4'h7;
                     end
                  end
                  MCS_INS_RJUMP: begin
                     if (state_reg == 4'h1) begin
                        state_next = cond_true_in ? 4'h3 : 4'h2;
                     end else if (state_reg == 4'h3) begin
                        offset_next = data_in;
                     end else if (state_reg == 4'h4) begin
                        state_next = offset_reg[MCS_SIGN_BIT] ? 4'h5 : 4'h6;
                     end
                  end
                  default: state_next = state_reg + 4'h1;
               endcase
            end
         end
      endcase
   end

   // ********************************************
   // Output next values
   // ********************************************
   always_comb begin
      addr_next = addr_of(dec_bus.src, opc_next, opcode_next, stack_pointer_in,
                          dest_next, src_next, periph_reg_in);
      rd_next   = (phase_next != MCS_PH_IDLE) && dec_bus.rd;
      wr_next   = (phase_next != MCS_PH_IDLE) && dec_bus.wr;
      dsel_next = (phase_next != MCS_PH_IDLE) ? dec_bus.dsel : MCS_DS_NONE;
      last_next = (phase_next != MCS_PH_IDLE) && dec_bus.last;
      busy_next = (phase_next != MCS_PH_IDLE);
   end

   // ********************************************
   // Registers
   // ********************************************
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         instr_reg  <= MCS_INS_NONE;
         form_reg   <= 2'h0;
         phase_reg  <= MCS_PH_IDLE;
         state_reg  <= MCS_STATE_RST;
         opc_reg    <= 16'h0000;
         opcode_reg <= 8'h00;
         offset_reg <= 8'h00;
         src_reg    <= 8'h00;
         dest_reg   <= 8'h00;
         last_reg   <= 1'b0;
         addr_out   <= 16'h0000;
         rd_out     <= 1'b0;
         wr_out     <= 1'b0;
         dsel_out   <= 3'h0;
         fetch_out  <= 1'b0;
         busy_out   <= 1'b0;
      end else begin
         instr_reg  <= instr_next;
         form_reg   <= form_next;
         phase_reg  <= phase_next;
         state_reg  <= state_next;
         opc_reg    <= opc_next;
         opcode_reg <= opcode_next;
         offset_reg <= offset_next;
         src_reg    <= src_next;
         dest_reg   <= dest_next;
         last_reg   <= last_next;
         addr_out   <= addr_next;
         rd_out     <= rd_next;
         wr_out     <= wr_next;
         dsel_out   <= dsel_next;
         fetch_out  <= fetch_next;
         busy_out   <= busy_next;
      end
   end

   assign state_out = state_reg;

   // ********************************************
   // Checks
   // ********************************************
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_b_in);

   logic btj_s2, rj_s1, dm_func;
   assign btj_s2  = phase_reg == MCS_PH_FUNC && state_reg == 4'h2
                    && (instr_reg == MCS_INS_BIT_ZERO || instr_reg == MCS_INS_BIT_ONE);
   assign rj_s1   = phase_reg == MCS_PH_FUNC && instr_reg == MCS_INS_RJUMP && state_reg == 4'h1;
   assign dm_func = phase_reg == MCS_PH_FUNC && instr_reg == MCS_INS_DMOVE;

   sequence imm_msb_s;
      rd_out && addr_out == opc_reg + 16'h0001;
   endsequence
   sequence imm_lsb_s;
      rd_out && addr_out == opc_reg + 16'h0002 ##1 rd_out ##1 !rd_out && !wr_out;
   endsequence

   zero_jump_a: assert property (btj_s2 && instr_reg == MCS_INS_BIT_ZERO && !bit_test_in
      |=> state_reg == 4'h4) else $error("Zero-bit jump not taken");
   one_jump_a: assert property (btj_s2 && instr_reg == MCS_INS_BIT_ONE
      |=> state_reg == (bit_test_in ? 4'h4 : 4'h3)) else $error("One-bit branch wrong");
   btj_sign_a: assert property (btj_s2 && taken ##2 !offset_reg[MCS_SIGN_BIT]
      |=> state_reg == 4'h7) else $error("Positive offset not skipping");
   pmove_src_a: assert property (phase_reg == MCS_PH_FUNC && instr_reg == MCS_INS_PMOVE
      |-> wr_out && dsel_out == (form_reg == 2'h0 ? MCS_DS_REG_A :
          form_reg == 2'h1 ? MCS_DS_REG_B : MCS_DS_IMM)) else $error("Move source wrong");
   dmove_imm_a: assert property (phase_reg == MCS_PH_ADDR && instr_reg == MCS_INS_DMOVE
      && form_reg == MCS_DM_IMM && state_reg == 4'h2 |-> imm_msb_s ##1 imm_lsb_s
      ##1 phase_reg == MCS_PH_FUNC) else $error("Immediate double move order");
   dest_fetch_a: assert property (dm_func && state_reg == 4'h2 |-> rd_out && addr_out ==
      opc_reg + (form_reg == MCS_DM_IDX ? 16'h0003 : 16'h0002)) else $error("Dest fetch");
   dmove_wr_a: assert property (dm_func && state_reg == 4'h5 |-> wr_out && addr_out[7:0] ==
      dest_reg ##1 !wr_out ##1 wr_out && addr_out[7:0] == dest_reg - 8'h01)
      else $error("Double move writes");
   rjump_cond_a: assert property (rj_s1 && !cond_true_in |=> state_reg == 4'h2 ##1 fetch_out)
      else $error("False relative jump");
   rjump_sign_a: assert property (rj_s1 && cond_true_in ##1 1'b1 ##1 offset_reg[MCS_SIGN_BIT]
      |=> state_reg == 4'h5) else $error("Negative offset not in 5");
   trap_vec_a: assert property (phase_reg == MCS_PH_FUNC && instr_reg == MCS_INS_TRAP
      && state_reg == 4'h3 |-> addr_out == MCS_TRAP_BASE + {8'h00, opcode_reg} ##4 wr_out
      ##4 state_reg == MCS_TRAP_LAST) else $error("Trap sequence wrong");
   fetch_ret_a: assert property (last_reg && phase_reg == MCS_PH_FUNC
      |=> fetch_out && !busy_out) else $error("No return to fetch");

endmodule : mcs_seq

// ===== verif/mcs_mem_model.sv
/*
 * Behavioural model of the far side of the sequencer bus: register file,
 * peripheral file and program memory in one flat byte array.
 * Assumes same-cycle read data and the single 100 MHz machine clock.
 */
`timescale 1ns/100ps
module mcs_mem_model
   import mcs_pkg::*;
(
   input  wire logic        core_clk_in,
   input  wire logic        rst_b_in,
   input  wire logic [15:0] addr_in,
   input  wire logic        rd_in,
   output logic [7:0]       data_out
);
   // ********************************************
   // Storage and released-bus behaviour
   // ********************************************
   logic [7:0] mem [0:65535];
   logic [7:0] last_reg;

   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'(i) ^ 8'h5a;
      end
   end

   // Released bus shows the inverse of the last byte, never a stale copy
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         last_reg <= 8'h00;
      end else if (rd_in) begin
         last_reg <= mem[addr_in];
      end
   end

   assign data_out = rd_in ? mem[addr_in] : ~last_reg;
endmodule : mcs_mem_model

// ===== verif/microcode_bus_cycle_sequencer_tb.sv
/*
 * Self-checking bench: per-state bus trace of every instruction class
 * compared against tables built here. Assumes the memory model partner.
 */
`timescale 1ns/100ps
module microcode_bus_cycle_sequencer_tb;
   import mcs_pkg::*;
   // ********************************************
   // Signals
   // ********************************************
   logic        core_clk_in, rst_b_in, start_in, bit_test_in, cond_true_in;
   logic [2:0]  instr_in;
   logic [1:0]  form_in;
   logic [15:0] opc_addr_in, addr_out;
   logic [7:0]  opcode_in, stack_pointer_in, periph_reg_in, data_in;
   logic        rd_out, wr_out, busy_out, fetch_out;
   logic [2:0]  dsel_out;
   logic [3:0]  state_out;
   int          err_count, checks, cyc;
   logic [25:0] exq [$];

   mcs_seq i_mcs_seq (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .start_in(start_in),
      .instr_in(instr_in), .form_in(form_in), .opc_addr_in(opc_addr_in),
      .opcode_in(opcode_in), .stack_pointer_in(stack_pointer_in),
      .periph_reg_in(periph_reg_in), .bit_test_in(bit_test_in),
      .cond_true_in(cond_true_in), .data_in(data_in), .addr_out(addr_out),
      .rd_out(rd_out), .wr_out(wr_out), .dsel_out(dsel_out), .state_out(state_out),
      .busy_out(busy_out), .fetch_out(fetch_out));

   mcs_mem_model i_mcs_mem_model (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
      .addr_in(addr_out), .rd_in(rd_out), .data_out(data_in));

   initial begin
      core_clk_in = 1'b0;
      forever #5 core_clk_in = ~core_clk_in;
   end

   always @(posedge core_clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         complete_run();
      end
   end

   // ********************************************
   // Common tasks
   // ********************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run();
      if (err_count == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : complete_run

   task automatic ex(input logic [3:0] s, input logic [1:0] rw, input logic [2:0] ds,
                     input logic [15:0] a);
      exq.push_back({1'b1, s, rw, ds, a});
   endtask : ex

   task automatic ex_idle(input logic [3:0] s);
      ex(s, 2'b00, 3'h0, 16'h0000);
   endtask : ex_idle

   task automatic ex_rd(input logic [3:0] s, input logic [15:0] a);
      ex(s, 2'b10, 3'h0, a);
   endtask : ex_rd

   // Launch, record one entry per state until the fetch pulse, compare
   task automatic run(input logic [2:0] ins, input logic [1:0] frm, input logic refuse);
      logic [25:0] seen [$];
      int          n;
      instr_in = ins;
      form_in = frm;
      start_in = 1'b1;
      @(posedge core_clk_in);
      #1;
      n = 0;
      while (fetch_out !== 1'b1 && n < 24) begin
         seen.push_back({busy_out, state_out, rd_out, wr_out, dsel_out, addr_out});
         start_in = refuse && n == 0;
         instr_in = (refuse && n == 0) ? 3'h5 : ins;
         n++;
         @(posedge core_clk_in);
         #1;
      end
      check(32'(fetch_out), 32'h1);
      check(32'(seen.size()), 32'(exq.size()));
      for (int i = 0; i < exq.size() && i < seen.size(); i++) begin
         check(32'(seen[i]), 32'(exq[i]));
      end
      exq.delete();
   endtask : run

   // ********************************************
   // Scenarios
   // ********************************************
   task automatic sc_bit_jump(input logic [2:0] ins, input logic bv, input logic [7:0] off);
      logic taken;
      taken = (ins == 3'(MCS_INS_BIT_ZERO)) ? ~bv : bv;
      opc_addr_in = 16'h2340;
      i_mcs_mem_model.mem[16'h2341] = off;
      bit_test_in = bv;
      ex_idle(4'h1);
      ex_rd(4'h2, 16'h2341);
      if (!taken) begin
         ex_rd(4'h3, 16'h2341);
      end else begin
         ex_rd(4'h4, 16'h2341);
         ex_idle(4'h5);
         ex_idle(off[7] ? 4'h6 : 4'h7);
      end
      run(ins, 2'h0, 1'b0);
   endtask : sc_bit_jump

   task automatic sc_rel_jump(input logic cond, input logic [7:0] off, input logic refuse);
      opc_addr_in = 16'h1ffe;
      i_mcs_mem_model.mem[16'h1fff] = off;
      cond_true_in = cond;
      ex_rd(4'h1, 16'h1fff);
      if (!cond) begin
         ex_rd(4'h2, 16'h1fff);
      end else begin
         ex_rd(4'h3, 16'h1fff);
         ex_idle(4'h4);
         ex_idle(off[7] ? 4'h5 : 4'h6);
      end
      run(3'(MCS_INS_RJUMP), 2'h0, refuse);
   endtask : sc_rel_jump

   task automatic sc_trap(input logic [7:0] op);
      opcode_in = op;
      stack_pointer_in = 8'h7e;
      ex_idle(4'h1);
      ex_idle(4'h2);
      ex_rd(4'h3, 16'hff00 + {8'h00, op});
      ex_rd(4'h4, 16'hff00 + {8'h00, op});
      ex_rd(4'h5, 16'hfeff + {8'h00, op});
      ex_rd(4'h6, 16'hfeff + {8'h00, op});
      ex(4'h7, 2'b01, 3'h1, 16'h007e);
      ex_idle(4'h8);
      ex(4'h9, 2'b01, 3'h2, 16'h007f);
      ex_idle(4'ha);
      ex_idle(4'hb);
      run(3'(MCS_INS_TRAP), 2'h0, 1'b0);
   endtask : sc_trap

   task automatic sc_pmove();
      periph_reg_in = 8'h3c;
      for (int f = 0; f < 4; f++) begin
         ex(4'h1, 2'b01, (f == 0) ? 3'h3 : (f == 1) ? 3'h4 : 3'h5, 16'h013c);
         ex(4'h2, 2'b01, (f == 0) ? 3'h3 : (f == 1) ? 3'h4 : 3'h5, 16'h013c);
         run(3'(MCS_INS_PMOVE), 2'(f), 1'b0);
      end
   endtask : sc_pmove

   task automatic sc_dmove(input logic [1:0] frm);
      logic [7:0]  dst;
      logic [15:0] dadr;
      opc_addr_in = 16'h4000;
      i_mcs_mem_model.mem[16'h4001] = 8'h21;
      i_mcs_mem_model.mem[16'h4002] = 8'h46;
      i_mcs_mem_model.mem[16'h4003] = 8'h58;
      dadr = (frm == 2'h3) ? 16'h4003 : 16'h4002;
      dst = (frm == 2'h3) ? 8'h58 : 8'h46;
      if (frm == 2'h1) begin
         ex_rd(4'h1, 16'h4001);
         ex_rd(4'h2, 16'h4001);
         ex_rd(4'h3, 16'h0021);
         ex_rd(4'h4, 16'h0020);
      end else begin
         if (frm == 2'h3) ex_idle(4'h1);
         for (int k = 0; k < 4; k++) begin
            ex_rd(4'(k + ((frm == 2'h3) ? 2 : 1)), (k < 2) ? 16'h4001 : 16'h4002);
         end
         ex_idle((frm == 2'h3) ? 4'h6 : 4'h5);
         if (frm == 2'h3) ex_idle(4'h7);
      end
      ex_idle(4'h1);
      ex_rd(4'h2, dadr);
      ex_rd(4'h3, dadr);
      ex_idle(4'h4);
      ex(4'h5, 2'b01, 3'h6, {8'h00, dst});
      ex_idle(4'h6);
      ex(4'h7, 2'b01, 3'h7, {8'h00, dst - 8'h01});
      run(3'(MCS_INS_DMOVE), frm, 1'b0);
   endtask : sc_dmove

   task automatic sc_ignored();
      instr_in = 3'h0;
      start_in = 1'b1;
      @(posedge core_clk_in);
      #1;
      check(32'({busy_out, state_out, rd_out, wr_out}), 32'h0);
      instr_in = 3'h7;
      @(posedge core_clk_in);
      #1;
      start_in = 1'b0;
      check(32'({busy_out, state_out, rd_out, wr_out}), 32'h0);
   endtask : sc_ignored

   // ********************************************
   // Main sequence
   // ********************************************
   initial begin
      {start_in, bit_test_in, cond_true_in, rst_b_in} = 4'h0;
      {instr_in, form_in, opc_addr_in, opcode_in} = '0;
      {stack_pointer_in, periph_reg_in} = 16'h0000;
      repeat (5) @(posedge core_clk_in);
      #1;
      check(32'({addr_out, rd_out, wr_out, dsel_out, state_out, busy_out, fetch_out}), 32'h0);
      rst_b_in = 1'b1;
      sc_bit_jump(3'(MCS_INS_BIT_ZERO), 1'b0, 8'h12);
      sc_bit_jump(3'(MCS_INS_BIT_ZERO), 1'b1, 8'h12);
      sc_bit_jump(3'(MCS_INS_BIT_ONE), 1'b1, 8'h80);
      sc_bit_jump(3'(MCS_INS_BIT_ONE), 1'b0, 8'h80);
      sc_bit_jump(3'(MCS_INS_BIT_ZERO), 1'b0, 8'hff);
      sc_rel_jump(1'b0, 8'h05, 1'b1);
      sc_rel_jump(1'b1, 8'h7f, 1'b0);
      sc_rel_jump(1'b1, 8'h80, 1'b1);
      sc_trap(8'h00);
      sc_trap(8'h08);
      sc_trap(8'h17);
      sc_pmove();
      sc_dmove(2'h0);
      sc_dmove(2'h1);
      sc_dmove(2'h3);
      sc_dmove(2'h2);
      sc_ignored();
      complete_run();
   end
endmodule : microcode_bus_cycle_sequencer_tb
